// >>> hdl/obsl_loader.sv
// top: reset-time loading of flash option bits into shadows and feature enables
`timescale 1ns/1ps
`include "obsl_params.svh"
module obsl_loader
  import obsl_pkg::*;
#(
  parameter int NBITS = `OBSL_NBITS,
  parameter int LOAD_CYCLES = `OBSL_LOAD_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_por,
  input wire logic i_stop_recovery,
  input wire logic i_reset_active,
  input wire logic [7:0] i_stop_recovery_control,
  input wire logic [NBITS-1:0] i_flash_option,
  output logic o_load_done,
  output logic [NBITS-1:0] o_shadow,
  output logic [1:0] o_pullup_port0,
  output logic [1:0] o_pullup_port1,
  output logic o_pullup_port2,
  output logic o_pullup_port3_low,
  output logic o_pullup_port4,
  output logic o_watchdog_timer_force_on,
  output logic o_flash_protect_all,
  output logic o_flash_protect_low,
  output logic o_stack_16bit,
  output logic o_sysclk_en
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int SW = 4 + NBITS;
  logic [SW-1:0] sync1, sync2;
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {i_por, i_stop_recovery, i_reset_active,
                i_stop_recovery_control[`OBSL_SRC_RELOAD_BIT], i_flash_option};
      sync2 <= sync1;
    end
  end
  wire por_s = sync2[SW-1];
  wire smr_s = sync2[SW-2];
  wire ract_s = sync2[SW-3];
  wire reload_s = sync2[SW-4];
  wire [NBITS-1:0] flash_s = sync2[NBITS-1:0];

  // ----------------------------------------
  // load sequencer
  // ----------------------------------------
  // qualifying reset: power-on always, stop recovery only with the reload bit
  wire qualify = por_s | (smr_s & reload_s);
  obsl_state_t state, next_state;
  logic ract_d;
  logic [7:0] cnt;
  logic pending;
  wire start = ract_s & ~ract_d;
  wire ending = ~ract_s & ract_d;
  // the read runs in the closing cycles after the reset request drops
  wire read_done = (state == OBSL_READ) && (cnt == 8'(LOAD_CYCLES - 1));
  obsl_if #(.NBITS(NBITS)) sb();
  assign sb.preset = start & qualify;
  assign sb.capture = read_done;
  assign sb.data = flash_s;

  always_comb
  begin
    next_state = state;
    case (state)
      OBSL_IDLE: if (ending && (pending || qualify)) next_state = OBSL_READ;
      OBSL_READ: if (read_done) next_state = OBSL_LOAD;
      OBSL_LOAD: next_state = OBSL_IDLE;
      default: next_state = OBSL_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= OBSL_IDLE;
      ract_d <= 1'b0;
      cnt <= 8'h00;
      pending <= 1'b1;
    end
    else
    begin
      state <= next_state;
      ract_d <= ract_s;
      cnt <= (state == OBSL_READ) ? cnt + 8'h01 : 8'h00;
      if (start && qualify)
        pending <= 1'b1;
      else if (state == OBSL_LOAD)
        pending <= 1'b0;
    end
  end

  obsl_shadow_bank #(.NBITS(NBITS), .PRESET(NBITS'(`OBSL_PRESET))) u_bank (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .bus(sb.bank)
  );

  // ----------------------------------------
  // feature enables
  // ----------------------------------------
  // flash programming never touches these; only the next reset load does
  wire [NBITS-1:0] sh = sb.shadow;
  logic div2;
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div2 <= 1'b0;
      o_sysclk_en <= 1'b0;
      o_load_done <= 1'b0;
      o_shadow <= '0;
      o_pullup_port0 <= 2'h0;
      o_pullup_port1 <= 2'h0;
      o_pullup_port2 <= 1'b0;
      o_pullup_port3_low <= 1'b0;
      o_pullup_port4 <= 1'b0;
      o_watchdog_timer_force_on <= 1'b0;
      o_flash_protect_all <= 1'b0;
      o_flash_protect_low <= 1'b0;
      o_stack_16bit <= 1'b0;
    end
    else
    begin
      div2 <= ~div2;
      o_sysclk_en <= sh[`OBSL_B_NODIV] | div2;
      o_load_done <= (state == OBSL_LOAD) | (o_load_done & ~(start & qualify));
      o_shadow <= sh;
      o_pullup_port0 <= {sh[`OBSL_B_P0H], sh[`OBSL_B_P0L]};
      o_pullup_port1 <= {sh[`OBSL_B_P1H], sh[`OBSL_B_P1L]};
      o_pullup_port2 <= sh[`OBSL_B_P2];
      o_pullup_port3_low <= sh[`OBSL_B_P3L];
      o_pullup_port4 <= sh[`OBSL_B_P4];
      o_watchdog_timer_force_on <= sh[`OBSL_B_WDOG];
      o_flash_protect_all <= sh[`OBSL_B_PROT_ALL];
      o_flash_protect_low <= sh[`OBSL_B_PROT_LOW];
      o_stack_16bit <= sh[`OBSL_B_STK16];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_capture_only_in_read;
    @(posedge i_mclk) disable iff (!rst_n)
    sb.capture |-> (state == OBSL_READ) && !ract_s;
  endproperty
  a_capture_only_in_read: assert property (p_capture_only_in_read)
    else $error("shadow captured outside load window");

  property p_hold;
    @(posedge i_mclk) disable iff (!rst_n)
    (!sb.capture && !sb.preset) |=> sb.shadow == $past(sb.shadow);
  endproperty
  a_hold: assert property (p_hold)
    else $error("shadow changed outside load window");

  property p_capture_value;
    @(posedge i_mclk) disable iff (!rst_n)
    sb.capture |=> sb.shadow == $past(flash_s);
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("shadow does not match flash on load");

  property p_smr_no_reload;
    @(posedge i_mclk) disable iff (!rst_n)
    (start && smr_s && !reload_s && !por_s) |-> !sb.preset;
  endproperty
  a_smr_no_reload: assert property (p_smr_no_reload)
    else $error("stop recovery reloaded without reload bit");

  property p_preset;
    @(posedge i_mclk) disable iff (!rst_n)
    (start && qualify) |=> sb.shadow == NBITS'(`OBSL_PRESET);
  endproperty
  a_preset: assert property (p_preset)
    else $error("shadow not preset at reset start");

  property p_por_loads;
    @(posedge i_mclk) disable iff (!rst_n)
    (ending && por_s && state == OBSL_IDLE) |=> ##[1:12] sb.capture;
  endproperty
  a_por_loads: assert property (p_por_loads)
    else $error("power-on reset did not load shadows");

  property p_div;
    @(posedge i_mclk) disable iff (!rst_n)
    (!sh[`OBSL_B_NODIV] && o_sysclk_en && $past(!sh[`OBSL_B_NODIV])) |=> !o_sysclk_en;
  endproperty
  a_div: assert property (p_div)
    else $error("divided clock enable not alternating");

  property p_feature;
    @(posedge i_mclk) disable iff (!rst_n)
    ##1 o_watchdog_timer_force_on == $past(sh[`OBSL_B_WDOG]);
  endproperty
  a_feature: assert property (p_feature)
    else $error("watchdog enable not following shadow");
endmodule

// >>> hdl/obsl_params.svh
// timing constants, bit positions and reset values for the option bit shadow loader
//
// Contract
// - one shadow flop per option bit; features read the flop, never the flash cell
// - power-on reset reads all option bits and captures them late in the reset period
// - stop-recovery reset reloads only when stop_recovery_control bit 5 is one
// - shadows needing a known value are forced to presets when a qualifying reset starts
// - programmed or erased options take effect only after a later reset
// - shadow outputs drive pull-ups, watchdog, flash protect, undivided clock, 16-bit stack
// - undivided option clear gives crystal input over two; set passes crystal directly
`ifndef OBSL_PARAMS_SVH
`define OBSL_PARAMS_SVH
`define OBSL_NBITS 12
`define OBSL_SRC_RELOAD_BIT 5
`define OBSL_LOAD_CYCLES 4
`define OBSL_PRESET 12'h000
`define OBSL_B_P0L 0
`define OBSL_B_P0H 1
`define OBSL_B_P1L 2
`define OBSL_B_P1H 3
`define OBSL_B_P2 4
`define OBSL_B_P3L 5
`define OBSL_B_P4 6
`define OBSL_B_WDOG 7
`define OBSL_B_PROT_ALL 8
`define OBSL_B_PROT_LOW 9
`define OBSL_B_NODIV 10
`define OBSL_B_STK16 11
`endif

// >>> hdl/obsl_pkg.sv
// types for the option bit shadow loader
package obsl_pkg;
  typedef enum logic [1:0] {
    OBSL_IDLE = 2'b00,
    OBSL_READ = 2'b01,
    OBSL_LOAD = 2'b10
  } obsl_state_t;
endpackage

// >>> hdl/obsl_if.sv
// handshake between the reset sequencer and the shadow bank
`timescale 1ns/1ps
interface obsl_if #(parameter int NBITS = 12);
  logic preset;
  logic capture;
  logic [NBITS-1:0] data;
  logic [NBITS-1:0] shadow;
  modport seq (output preset, output capture, output data, input shadow);
  modport bank (input preset, input capture, input data, output shadow);
endinterface

// >>> hdl/obsl_shadow_bank.sv
// one shadow flop per option bit
`timescale 1ns/1ps
module obsl_shadow_bank #(
  parameter int NBITS = 12,
  parameter logic [NBITS-1:0] PRESET = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  obsl_if.bank bus
);
  // ----------------------------------------
  // shadow flops
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBITS; g++)
    begin : g_bit
      logic q;
      always_ff @(posedge i_mclk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          q <= 1'b0;
        else if (bus.preset)
          q <= PRESET[g];
        else if (bus.capture)
          q <= bus.data[g];
      end
      assign bus.shadow[g] = q; // holds otherwise
    end
  endgenerate
endmodule

// >>> testbench/obsl_flash_model.sv
// behavioural model of the flash information block holding the option bits
`timescale 1ns/1ps
module obsl_flash_model #(
  parameter int NBITS = 12
) (
  input wire logic i_mclk,
  output logic [NBITS-1:0] o_option
);
  logic [NBITS-1:0] cells = '0;
  // cells present their level at all times, so only the shadow may gate features
  assign o_option = cells;
  // programming only changes the cells; the bench must reset for them to apply
  task program_cells(input logic [NBITS-1:0] v);
    @(posedge i_mclk);
    cells <= v;
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the option bit shadow loader
`timescale 1ns/1ps
`include "obsl_params.svh"
module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_por = 1'b0;
  logic i_stop_recovery = 1'b0;
  logic i_reset_active = 1'b0;
  logic [7:0] i_stop_recovery_control = 8'h00;
  logic [11:0] flash_option;
  logic [11:0] o_shadow;
  logic [1:0] o_pullup_port0, o_pullup_port1;
  logic o_load_done, o_pullup_port2, o_pullup_port3_low, o_pullup_port4;
  logic o_watchdog_timer_force_on, o_flash_protect_all, o_flash_protect_low;
  logic o_stack_16bit, o_sysclk_en;
  int miscompares = 0;
  int n_checks = 0;
  always #5 i_mclk = ~i_mclk;
  obsl_flash_model obsl_flash_model_i (.i_mclk(i_mclk), .o_option(flash_option));
  obsl_loader obsl_loader_i (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_por(i_por),
    .i_stop_recovery(i_stop_recovery), .i_reset_active(i_reset_active),
    .i_stop_recovery_control(i_stop_recovery_control), .i_flash_option(flash_option),
    .o_load_done(o_load_done), .o_shadow(o_shadow),
    .o_pullup_port0(o_pullup_port0), .o_pullup_port1(o_pullup_port1),
    .o_pullup_port2(o_pullup_port2), .o_pullup_port3_low(o_pullup_port3_low),
    .o_pullup_port4(o_pullup_port4), .o_watchdog_timer_force_on(o_watchdog_timer_force_on),
    .o_flash_protect_all(o_flash_protect_all), .o_flash_protect_low(o_flash_protect_low),
    .o_stack_16bit(o_stack_16bit), .o_sysclk_en(o_sysclk_en));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // nodiv has no pin of its own, so its slot is filled from the shadow copy
  task check_features(input logic [11:0] e);
    check({o_stack_16bit, o_shadow[`OBSL_B_NODIV], o_flash_protect_low, o_flash_protect_all,
      o_watchdog_timer_force_on, o_pullup_port4, o_pullup_port3_low, o_pullup_port2,
      o_pullup_port1, o_pullup_port0}, e, "feature enables");
  endtask
  task check_clock(input logic nodiv);
    int highs;
    highs = 0;
    repeat (4)
    begin
      @(negedge i_mclk);
      if (o_sysclk_en === 1'b1)
        highs++;
    end
    check(12'(highs), nodiv ? 12'h004 : 12'h002, "clock enables in four cycles");
  endtask
  // a fixed wait of 12 cycles covers the eight-cycle load walk with margin
  task reset_period(input logic por, input logic stop_recovery_control, input logic reload,
    input logic [11:0] during, input logic [11:0] after);
    @(posedge i_mclk);
    i_por <= por;
    i_stop_recovery <= stop_recovery_control;
    i_stop_recovery_control <= {2'b00, reload, 5'h00};
    i_reset_active <= 1'b1;
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    check(o_shadow, during, "shadow inside reset");
    @(posedge i_mclk);
    i_reset_active <= 1'b0;
    repeat (12) @(negedge i_mclk);
    check(12'(o_load_done), 12'h001, "load done");
    check(o_shadow, after, "shadow after reset");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #20000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    obsl_flash_model_i.program_cells(12'h1a5);
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    reset_period(1'b1, 1'b0, 1'b0, `OBSL_PRESET, 12'h1a5);
    check_features(12'h1a5);
    check_clock(1'b0);
    $display("test power-on load finished");
    obsl_flash_model_i.program_cells(12'hc5a);
    repeat (10) @(negedge i_mclk);
    check(o_shadow, 12'h1a5, "shadow after programming");
    check_features(12'h1a5);
    $display("test hold after programming finished");
    reset_period(1'b0, 1'b1, 1'b0, 12'h1a5, 12'h1a5);
    $display("test stop recovery without reload finished");
    reset_period(1'b0, 1'b1, 1'b1, `OBSL_PRESET, 12'hc5a);
    check_features(12'hc5a);
    check_clock(1'b1);
    $display("test stop recovery reload finished");
    obsl_flash_model_i.program_cells(12'h2f0);
    reset_period(1'b1, 1'b0, 1'b0, `OBSL_PRESET, 12'h2f0);
    check_features(12'h2f0);
    check_clock(1'b0);
    $display("test second power-on load finished");
    end_of_test();
  end
endmodule
